// ### design/tbm_regs.svh
`ifndef TBM_REGS_SVH
`define TBM_REGS_SVH
`define TBM_OFS_CTRL1   12'h000
`define TBM_OFS_CTRL2   12'h004
`define TBM_OFS_MODE    12'h008
`define TBM_OFS_IEN     12'h00c
`define TBM_OFS_STAT    12'h010
`define TBM_OFS_ADDR    12'h014
`define TBM_OFS_NF      12'h018
`define TBM_OFS_PINS    12'h01c
// bus_control_register_one fields
`define TBM_C1_ON       7
`define TBM_C1_SRST     6
`define TBM_C1_MST      5
`define TBM_C1_TRS      4
// bus_control_register_two fields
`define TBM_C2_BUSY     7
`define TBM_C2_SCP      6
`define TBM_C2_DATA_LINE_OUT_BIT     5
`define TBM_C2_SDAOP    4
`define TBM_C2_CLOCK_LINE_OUT_BIT     3
// bus_status_register fields
`define TBM_ST_TRANSMIT_EMPTY_FLAG     7
`define TBM_ST_TRANSMIT_FINISHED_FLAG     6
`define TBM_ST_RECEIVE_FULL_FLAG     5
`define TBM_ST_NACK     4
`define TBM_ST_STOP     3
`define TBM_ST_ALOV     2
`define TBM_ST_AAS      1
`define TBM_ST_GC       0
// own_address_register force-idle bit
`define TBM_AD_FS       0
`define TBM_RST_STAT    8'h80
`define TBM_RST_C2      8'h38
`define TBM_ADDR_W      12
`define TBM_GEN_HALF    16'h00f9
`endif

// ### design/tbm_pkg.sv
package tbm_pkg;
  typedef enum logic [1:0] {
    TBM_SLV_RX = 2'b00,
    TBM_SLV_TX = 2'b01,
    TBM_MST_RX = 2'b10,
    TBM_MST_TX = 2'b11
  } tbm_mode_type;
  typedef enum logic [1:0] {
    TBM_GEN_IDLE = 2'b00,
    TBM_GEN_HOLD = 2'b01,
    TBM_GEN_EDGE = 2'b11
  } tbm_gen_type;
endpackage

// ### design/tbm_line_if.sv
`timescale 1ns/100ps
interface tbm_line_if;
  logic scl_lvl;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  modport mon (input scl_lvl, input sda_lvl, output start_det, output stop_det);
  modport top (output scl_lvl, output sda_lvl, input start_det, input stop_det);
endinterface

// ### design/tbm_cond_det.sv
`timescale 1ns/100ps
module tbm_cond_det
  import tbm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tbm_line_if.mon  lines
);
  logic scl_d_r;
  logic sda_d_r;
  logic scl_d_nxt;
  logic sda_d_nxt;

  // ****************************************
  // Start and stop recognition
  // ****************************************
  always_comb begin
    scl_d_nxt = lines.scl_lvl;
    sda_d_nxt = lines.sda_lvl;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  assign lines.start_det = scl_d_r && lines.scl_lvl && sda_d_r && !lines.sda_lvl;
  assign lines.stop_det  = scl_d_r && lines.scl_lvl && !sda_d_r && lines.sda_lvl;
endmodule

// ### design/tbm_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "tbm_regs.svh"
module tbm_top
  import tbm_pkg::*;
#(
  parameter int GEN_HALF = `TBM_GEN_HALF
)(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`TBM_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe_n,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n
);
  // The counter is 16 bits wide and each half needs at least three cycles
  if (GEN_HALF < 2 || GEN_HALF > 65535) begin : g_half_check
    $error("GEN_HALF out of range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic [1:0] scl_s_nxt;
  logic [1:0] sda_s_nxt;
  tbm_line_if lines ();

  // Reset to the idle high level so no false edge follows reset
  always_comb begin
    scl_s_nxt = {scl_s_r[0], scl_in};
    sda_s_nxt = {sda_s_r[0], sda_in};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
    end
  end

  assign lines.scl_lvl = scl_s_r[1];
  assign lines.sda_lvl = sda_s_r[1];

  // Runs regardless of module_on_bit and soft reset
  tbm_cond_det u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .lines   (lines)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl1_nxt;
  logic [7:0]  ctrl2_r;
  logic [7:0]  ctrl2_nxt;
  logic [7:0]  mode_r;
  logic [7:0]  mode_nxt;
  logic [7:0]  ien_r;
  logic [7:0]  ien_nxt;
  logic [7:0]  stat_r;
  logic [7:0]  stat_nxt;
  logic [7:0]  addr_r;
  logic [7:0]  addr_nxt;
  logic [7:0]  nf_r;
  logic [7:0]  nf_nxt;
  tbm_gen_type gen_r;
  tbm_gen_type gen_nxt;
  logic        gen_start_r;
  logic        gen_start_nxt;
  logic [15:0] gcnt_r;
  logic [15:0] gcnt_nxt;
  logic        drv_sda_r;
  logic        drv_sda_nxt;
  logic        drv_scl_r;
  logic        drv_scl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic        wr;
  logic        rd;
  logic        srst;
  logic        on;
  logic        addr_ok;
  tbm_mode_type mode;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign srst    = ctrl1_r[`TBM_C1_SRST];
  assign on      = ctrl1_r[`TBM_C1_ON];
  assign mode    = tbm_mode_type'({ctrl1_r[`TBM_C1_MST], ctrl1_r[`TBM_C1_TRS]});
  // Eight word registers from offset zero; the rest answer with an error
  assign addr_ok = (paddr[`TBM_ADDR_W-1:5] == '0) && (paddr[1:0] == 2'b00);

  always_comb begin
    ctrl1_nxt     = ctrl1_r;
    ctrl2_nxt     = ctrl2_r;
    mode_nxt      = mode_r;
    ien_nxt       = ien_r;
    stat_nxt      = stat_r;
    addr_nxt      = addr_r;
    nf_nxt        = nf_r;
    gen_nxt       = gen_r;
    gen_start_nxt = gen_start_r;
    gcnt_nxt      = gcnt_r;
    drv_sda_nxt   = drv_sda_r;
    drv_scl_nxt   = drv_scl_r;
    if (wr && addr_ok) begin
      case (paddr)
        `TBM_OFS_CTRL1: begin
          ctrl1_nxt = {pwdata[7:4], 4'h0};
          if (pwdata[`TBM_C1_SRST] && !srst) begin
            ctrl2_nxt[`TBM_C2_DATA_LINE_OUT_BIT] = 1'b1;
            ctrl2_nxt[`TBM_C2_CLOCK_LINE_OUT_BIT] = 1'b1;
            gen_nxt     = TBM_GEN_IDLE;
            drv_sda_nxt = 1'b1;
            drv_scl_nxt = 1'b1;
            if (mode == TBM_MST_TX || mode == TBM_SLV_TX) begin
              stat_nxt[`TBM_ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
            end
          end
        end
        `TBM_OFS_CTRL2: begin
          if (!srst) begin
            if (pwdata[`TBM_C2_SDAOP]) begin
              ctrl2_nxt[`TBM_C2_DATA_LINE_OUT_BIT] = pwdata[`TBM_C2_DATA_LINE_OUT_BIT];
            end
            if (!pwdata[`TBM_C2_SCP] && on && gen_r == TBM_GEN_IDLE) begin
              if (pwdata[`TBM_C2_BUSY] && mode == TBM_MST_TX && lines.scl_lvl
                  && lines.sda_lvl) begin
                gen_nxt       = TBM_GEN_HOLD;
                gen_start_nxt = 1'b1;
                gcnt_nxt      = '0;
              end else if (!pwdata[`TBM_C2_BUSY] && ctrl1_r[`TBM_C1_MST]
                           && !lines.sda_lvl) begin
                gen_nxt       = TBM_GEN_HOLD;
                gen_start_nxt = 1'b0;
                gcnt_nxt      = '0;
                drv_sda_nxt   = 1'b0;
                drv_scl_nxt   = 1'b1;
              end
            end
          end
        end
        `TBM_OFS_MODE: mode_nxt = pwdata[7:0];
        `TBM_OFS_IEN:  ien_nxt  = pwdata[7:0];
        `TBM_OFS_STAT: stat_nxt = stat_r & pwdata[7:0];
        `TBM_OFS_ADDR: addr_nxt = pwdata[7:0];
        `TBM_OFS_NF:   nf_nxt   = pwdata[7:0];
        default: ;
      endcase
    end

    // Line generator for forced start and stop: hold half a bit, then move a line
    case (gen_r)
      TBM_GEN_HOLD: begin
        gcnt_nxt = gcnt_r + 16'h0001;
        if (gcnt_r == 16'(GEN_HALF)) begin
          gcnt_nxt = '0;
          gen_nxt  = TBM_GEN_EDGE;
          if (gen_start_r) begin
            drv_sda_nxt = 1'b0;
          end else if (lines.scl_lvl) begin
            drv_sda_nxt = 1'b1;
          end else begin
            gen_nxt = TBM_GEN_HOLD;
          end
        end
      end
      // Second half: a start also pulls the clock low to claim the bus
      TBM_GEN_EDGE: begin
        gcnt_nxt = gcnt_r + 16'h0001;
        if (gcnt_r == 16'(GEN_HALF)) begin
          gen_nxt = TBM_GEN_IDLE;
          if (gen_start_r) begin
            drv_scl_nxt = 1'b0;
          end
        end
      end
      default: ;
    endcase

    // Bus state follows the line; hardware set/clear wins over software
    // Start beats the force-idle clear when both land in one cycle
    if (lines.start_det) begin
      ctrl2_nxt[`TBM_C2_BUSY] = 1'b1;
    end else if (lines.stop_det) begin
      ctrl2_nxt[`TBM_C2_BUSY] = 1'b0;
      stat_nxt[`TBM_ST_STOP]  = 1'b1;
    end else if (wr && paddr == `TBM_OFS_ADDR && pwdata[`TBM_AD_FS]) begin
      ctrl2_nxt[`TBM_C2_BUSY] = 1'b0;
    end

    // Soft reset comes last so a generator step in the entry cycle
    // cannot pull a line low for one cycle
    if (srst || ctrl1_nxt[`TBM_C1_SRST]) begin
      ctrl2_nxt[`TBM_C2_DATA_LINE_OUT_BIT] = 1'b1;
      ctrl2_nxt[`TBM_C2_CLOCK_LINE_OUT_BIT] = 1'b1;
      gen_nxt     = TBM_GEN_IDLE;
      drv_sda_nxt = 1'b1;
      drv_scl_nxt = 1'b1;
    end
    // Unused bits always read zero; the write-protect bit resets to one and clears on the first clock
    ctrl2_nxt[`TBM_C2_SDAOP] = 1'b0;
    ctrl2_nxt[2:0]           = 3'b000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r     <= 8'h00;
      ctrl2_r     <= `TBM_RST_C2;
      mode_r      <= 8'h00;
      ien_r       <= 8'h00;
      stat_r      <= `TBM_RST_STAT;
      addr_r      <= 8'h00;
      nf_r        <= 8'h00;
      gen_r       <= TBM_GEN_IDLE;
      gen_start_r <= 1'b0;
      gcnt_r      <= 16'h0000;
      drv_sda_r   <= 1'b1;
      drv_scl_r   <= 1'b1;
    end else begin
      ctrl1_r     <= ctrl1_nxt;
      ctrl2_r     <= ctrl2_nxt;
      mode_r      <= mode_nxt;
      ien_r       <= ien_nxt;
      stat_r      <= stat_nxt;
      addr_r      <= addr_nxt;
      nf_r        <= nf_nxt;
      gen_r       <= gen_nxt;
      gen_start_r <= gen_start_nxt;
      gcnt_r      <= gcnt_nxt;
      drv_sda_r   <= drv_sda_nxt;
      drv_scl_r   <= drv_scl_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Loaded in the setup cycle so the data stands through the access phase
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `TBM_OFS_CTRL1: prdata_nxt = {24'h0, ctrl1_r};
        `TBM_OFS_CTRL2: prdata_nxt = {24'h0, ctrl2_r};
        `TBM_OFS_MODE:  prdata_nxt = {24'h0, mode_r};
        `TBM_OFS_IEN:   prdata_nxt = {24'h0, ien_r};
        `TBM_OFS_STAT:  prdata_nxt = {24'h0, stat_r};
        `TBM_OFS_ADDR:  prdata_nxt = {24'h0, addr_r};
        `TBM_OFS_NF:    prdata_nxt = {24'h0, nf_r};
        `TBM_OFS_PINS:  prdata_nxt = {30'h0, lines.sda_lvl, lines.scl_lvl};
        default:        prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Zero wait states: every access ends in its first access cycle
  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = (rd || wr) && !addr_ok;

  // ****************************************
  // Pin drive
  // ****************************************
  // Open drain: the level stays low and only the enable moves
  logic sda_low;
  logic scl_low;
  assign sda_low  = !ctrl2_r[`TBM_C2_DATA_LINE_OUT_BIT] || !drv_sda_r;
  assign scl_low  = !ctrl2_r[`TBM_C2_CLOCK_LINE_OUT_BIT] || !drv_scl_r;
  assign sda_out  = 1'b0;
  assign scl_out  = 1'b0;
  assign sda_oe_n = !(on && sda_low);
  assign scl_oe_n = !(on && scl_low);
endmodule

// ### bench/tbm_top_asserts.sv
`timescale 1ns/100ps
`include "tbm_regs.svh"
module tbm_top_asserts
  import tbm_pkg::*;
#(
  parameter int GEN_HALF = 4
)(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`TBM_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   scl_in,
  input wire logic                   scl_out,
  input wire logic                   scl_oe_n,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe_n
);
  // ***********
  // Checks
  // ***********
  logic on_r, on_nxt, srst_r, srst_nxt, acc, wr1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_comb begin
    acc = psel && penable;
    wr1 = acc && pwrite && paddr == `TBM_OFS_CTRL1;
    on_nxt = wr1 ? pwdata[`TBM_C1_ON] : on_r;
    srst_nxt = wr1 ? pwdata[`TBM_C1_SRST] : srst_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      on_r <= on_nxt;
      srst_r <= srst_nxt;
    end
  end
  pready_high_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (acc |-> pslverr == (paddr > `TBM_OFS_PINS || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  slverr_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  rdata_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  lines_low_a: assert property (!scl_out && !sda_out) else $error("line driven high");
  off_no_drive_a: assert property (!on_r |-> scl_oe_n && sda_oe_n)
    else $error("line driven while off");
  reset_release_a: assert property (srst_r |-> scl_oe_n && sda_oe_n)
    else $error("line driven in soft reset");
  gen_hold_a: assert property (acc && pwrite && paddr == `TBM_OFS_CTRL2 && pwdata[7] &&
    !pwdata[6] && on_r && !srst_r |=> sda_oe_n [*4]) else $error("start issued early");
  cover property (acc && pslverr);
  cover property (on_r && $fell(sda_oe_n));
  cover property (srst_r && acc && pwrite);
endmodule
bind tbm_top tbm_top_asserts #(.GEN_HALF(GEN_HALF)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// ### bench/tbm_bus_peer.sv
`timescale 1ns/100ps
module tbm_bus_peer (
  output logic scl_pull_n,
  output logic sda_pull_n
);
  // ***********
  // Other bus device, lines idle released
  // ***********
  initial begin
    scl_pull_n = 1'b1;
    sda_pull_n = 1'b1;
  end
  task automatic start_cond();
    sda_pull_n <= 1'b0;
    #80;
    scl_pull_n <= 1'b0;
    #80;
  endtask
  task automatic stop_cond();
    sda_pull_n <= 1'b0;
    #80;
    scl_pull_n <= 1'b1;
    #80;
    sda_pull_n <= 1'b1;
    #80;
  endtask
endmodule

// ### bench/test_i2c_reset_and_bus_busy_control.sv
`timescale 1ns/100ps
`include "tbm_regs.svh"
module test_i2c_reset_and_bus_busy_control
  import tbm_pkg::*;
;
  // ***********
  // Bench
  // ***********
  logic                   pclk, presetn, psel, penable, pwrite, err;
  logic [`TBM_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic                   scl_pull_n, sda_pull_n;
  logic [7:0]             rv;
  wire                    scl_w, sda_w;
  int                     errors, n_checks, cyc, i;
  int                     m_stat = 32'h80;
  int                     m_ctrl1;
  logic                   scl_p = 1'b1;
  logic                   sda_p = 1'b1;
  tbm_mode_type           md;
  assign scl_w = (scl_oe_n | scl_out) & scl_pull_n;
  assign sda_w = (sda_oe_n | sda_out) & sda_pull_n;
  tbm_top #(.GEN_HALF(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  tbm_bus_peer u_peer (.scl_pull_n(scl_pull_n), .sda_pull_n(sda_pull_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Model: a stop seen on the wires sets the stop flag
  always @(posedge pclk) begin
    scl_p <= scl_w;
    sda_p <= sda_w;
    if (scl_p && scl_w && !sda_p && sda_w) m_stat = m_stat | (1 << `TBM_ST_STOP);
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
      errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (w && a == `TBM_OFS_STAT) m_stat = m_stat & int'(d[7:0]);
    if (w && a == `TBM_OFS_CTRL1) begin
      if (d[`TBM_C1_SRST] && !m_ctrl1[`TBM_C1_SRST] && m_ctrl1[`TBM_C1_TRS])
        m_stat = m_stat | (1 << `TBM_ST_TRANSMIT_EMPTY_FLAG);
      m_ctrl1 = int'(d & 32'hf0);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wait_busy(input logic e);
    apb(1'b0, `TBM_OFS_CTRL2, 32'h0);
    for (int k = 0; k < 30 && rd[7] !== e; k++) apb(1'b0, `TBM_OFS_CTRL2, 32'h0);
    chk("busy flag", {31'h0, e}, {31'h0, rd[7]});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(8279));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl2 reset", `TBM_OFS_CTRL2, 32'h28);
    rchk("status reset", `TBM_OFS_STAT, m_stat);
    u_peer.start_cond();
    wait_busy(1'b1);
    u_peer.stop_cond();
    wait_busy(1'b0);
    rchk("stop flag", `TBM_OFS_STAT, m_stat);
    apb(1'b1, `TBM_OFS_CTRL1, 32'h40);
    apb(1'b1, `TBM_OFS_CTRL2, 32'h80);
    rchk("ctrl2 in reset", `TBM_OFS_CTRL2, 32'h28);
    u_peer.start_cond();
    wait_busy(1'b1);
    u_peer.stop_cond();
    wait_busy(1'b0);
    apb(1'b1, `TBM_OFS_CTRL1, 32'h0);
    u_peer.start_cond();
    wait_busy(1'b1);
    apb(1'b1, `TBM_OFS_ADDR, 32'h1);
    wait_busy(1'b0);
    apb(1'b1, `TBM_OFS_ADDR, 32'h0);
    u_peer.stop_cond();
    rchk("pins released", `TBM_OFS_PINS, 32'h3);
    for (i = 0; i < 4; i++) begin
      md = tbm_mode_type'(i);
      apb(1'b1, `TBM_OFS_CTRL1, 32'h0);
      apb(1'b1, `TBM_OFS_STAT, 32'h0);
      apb(1'b1, `TBM_OFS_CTRL1, {26'h0, md, 4'h0});
      apb(1'b1, `TBM_OFS_CTRL1, {25'h0, 1'b1, md, 4'h0});
      rchk("empty flag", `TBM_OFS_STAT, m_stat);
    end
    apb(1'b1, `TBM_OFS_CTRL1, 32'h0);
    rv = 8'($urandom);
    apb(1'b1, `TBM_OFS_IEN, {24'h0, rv});
    rchk("ien", `TBM_OFS_IEN, {24'h0, rv});
    rchk("unmapped", 12'h020 + {2'h0, rv, 2'h0}, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, `TBM_OFS_CTRL1, 32'hb0);
    apb(1'b1, `TBM_OFS_CTRL2, 32'ha8);
    wait_busy(1'b1);
    chk("data line", 32'h0, {31'h0, sda_w});
    chk("clock line", 32'h0, {31'h0, scl_w});
    apb(1'b1, `TBM_OFS_CTRL2, 32'h28);
    wait_busy(1'b0);
    chk("data line", 32'h1, {31'h0, sda_w});
    chk("clock line", 32'h1, {31'h0, scl_w});
    rchk("stop flag", `TBM_OFS_STAT, m_stat);
    apb(1'b1, `TBM_OFS_CTRL1, 32'h0);
    results();
  end
endmodule
